// file: hdl/synth_params.svh
// constants for the serial-programmed synthesizer dividers
`ifndef SYNTH_PARAMS_SVH
`define SYNTH_PARAMS_SVH
// ==========================================================
// program word
`define SYN_WORD_W 20
`define SYN_WORD_BITS 5'h14
`define SYN_DEFAULT_WORD 20'h04c7a
// field positions, first shifted bit ends up at the top
`define SYN_PDE_BIT 19
`define SYN_PDT_BIT 18
`define SYN_REF_SEL_BIT 17
`define SYN_REF_HI 16
`define SYN_REF_LO 12
`define SYN_MAIN_SEL_BIT 11
`define SYN_MAIN_HI 10
`define SYN_MAIN_LO 4
`define SYN_LO2_HI 3
`define SYN_LO2_LO 0
// ==========================================================
// pin sampler lanes
`define SYN_PIN_DATA 0
`define SYN_PIN_SCLK 1
`define SYN_PIN_LATCH 2
`define SYN_PIN_VCO 3
`define SYN_PIN_REF 4
// sampler reset to the idle levels: latch and serial clock parked high
`define SYN_PIN_IDLE 5'h06
// ==========================================================
// fixed dividers
`define SYN_DIV3_LAST 8'h02
// ==========================================================
// host timing (kept by the host, not checked here)
`define SYN_CLK_PERIOD_NS 10
`define SYN_HOST_SETUP_NS 30
`define SYN_HOST_SETUP_CYC ((`SYN_HOST_SETUP_NS + `SYN_CLK_PERIOD_NS - 1) / `SYN_CLK_PERIOD_NS)
`endif

// file: hdl/synth_pkg.sv
// types shared by the synthesizer divider block
package synth_pkg;
    // ==========================================================
    // power modes, one-hot
    typedef enum logic [3:0] {
        PM_NORMAL = 4'b0001,
        PM_PARTIAL = 4'b0010,
        PM_UNDEF = 4'b0100,
        PM_OFF = 4'b1000
    } power_mode_t;
endpackage

// file: hdl/serial_programmed_synth_dividers.sv
// three-wire program port and divider chains of the synthesizer
`timescale 1ns/1ns
`include "synth_params.svh"
// ==========================================================
// What this block does
// R1 - shift data in on each serial clock rise while latch is low
// R2 - host holds serial clock high 30 ns before moving the latch
// R3 - latch low at power-up gives the built-in default word
// R4 - bit order: pd enable, pd type, ref sel, ref value, main sel, main
// R5 - pd bits pick normal, partial or complete power-down
// R6 - ref sel low adds a divide-by-2 after the ref divider
// R7 - ref divider value is five bits msb first, 4 to 31
// R8 - total ref ratio is value, or double it when sel is low
// R9 - main sel low adds a divide-by-2 before the phase detector
// R10 - main divider value is seven bits msb first, 64 to 127
// R11 - fixed divide-by-2 after the main divider gives even ratios
// R12 - main path: /2, /3, programmable, /2, selectable /1 or /2
// R13 - second LO: prescaler output, programmable divider, then /2
// R14 - ref path: programmable divider then selectable /1 or /2
// R15 - last four bits set the second LO divider, msb first
// R16 - latch rising after a full word loads it into the settings
// R17 - settings stay unchanged while the latch is low
module serial_programmed_synth_dividers (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic serialData,
    input wire logic serialClock,
    input wire logic loadLatch,
    input wire logic vcoClock,
    input wire logic refClock,
    output logic powerDownEnable,
    output logic powerDownType,
    output logic rfEnable,
    output logic synthEnable,
    output logic refPdOut,
    output logic mainPdOut,
    output logic lo2Out
);

    // ==========================================================
    // helpers

    // next count of a wrapping divider; ratios below 2 pulse on every event
    function automatic logic [7:0] wrapCount(input logic [7:0] cnt, input logic [7:0] ratio);
        logic [7:0] inc;
        inc = 8'(cnt + 8'h01);
        wrapCount = (inc >= ratio) ? 8'h00 : inc;
    endfunction

    // ==========================================================
    // pin sampling

    logic [4:0] pinMeta;
    logic [4:0] pinSync;
    logic [4:0] pinPrev;

    // two flops per pin, then one more for edge finding
    // idle reset levels, so an idle latch gives no false rise after reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinMeta <= `SYN_PIN_IDLE;
            pinSync <= `SYN_PIN_IDLE;
            pinPrev <= `SYN_PIN_IDLE;
        end else begin
            pinMeta <= {refClock, vcoClock, loadLatch, serialClock, serialData};
            pinSync <= pinMeta;
            pinPrev <= pinSync;
        end
    end

    logic dataS;
    logic sclkRise;
    logic latchLow;
    logic latchRise;
    logic vcoRise;
    logic refRise;
    assign dataS = pinSync[`SYN_PIN_DATA];
    assign sclkRise = pinSync[`SYN_PIN_SCLK] & ~pinPrev[`SYN_PIN_SCLK];
    assign latchLow = ~pinSync[`SYN_PIN_LATCH];
    assign latchRise = pinSync[`SYN_PIN_LATCH] & ~pinPrev[`SYN_PIN_LATCH];
    assign vcoRise = pinSync[`SYN_PIN_VCO] & ~pinPrev[`SYN_PIN_VCO];
    assign refRise = pinSync[`SYN_PIN_REF] & ~pinPrev[`SYN_PIN_REF];

    // ==========================================================
    // serial program port

    logic [`SYN_WORD_W-1:0] shiftWord;
    logic [4:0] bitCount;
    logic [`SYN_WORD_W-1:0] activeWord;

    // data and clock share the same sampler delay, so setup is kept
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shiftWord <= '0;
            bitCount <= 5'h00;
        end else if (sclkRise && latchLow) begin
            shiftWord <= {shiftWord[`SYN_WORD_W-2:0], dataS}; // see R1
            if (bitCount != `SYN_WORD_BITS) begin
                bitCount <= 5'(bitCount + 5'h01);
            end
        end else if (latchRise) begin
            bitCount <= 5'h00;
        end
    end

    // short words are dropped so a power-up with latch low keeps the default
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            activeWord <= `SYN_DEFAULT_WORD; // see R3
        end else if (latchRise && bitCount == `SYN_WORD_BITS) begin
            activeWord <= shiftWord; // see R16 see R17
        end
    end

    // field split of the active word
    logic refSel;
    logic mainSel;
    logic [4:0] refValue;
    logic [6:0] mainValue;
    logic [3:0] lo2Value;
    assign powerDownEnable = activeWord[`SYN_PDE_BIT]; // see R4
    assign powerDownType = activeWord[`SYN_PDT_BIT];
    assign refSel = activeWord[`SYN_REF_SEL_BIT];
    assign refValue = activeWord[`SYN_REF_HI:`SYN_REF_LO]; // see R7
    assign mainSel = activeWord[`SYN_MAIN_SEL_BIT];
    assign mainValue = activeWord[`SYN_MAIN_HI:`SYN_MAIN_LO]; // see R10
    assign lo2Value = activeWord[`SYN_LO2_HI:`SYN_LO2_LO]; // see R15

    // ==========================================================
    // power modes

    synth_pkg::power_mode_t powerMode;
    logic next_rfEnable;
    logic next_synthEnable;

    // undefined code keeps everything running, the safest guess
    always_comb begin
        powerMode = (powerDownEnable && powerDownType) ? synth_pkg::PM_OFF :
                    powerDownEnable ? synth_pkg::PM_PARTIAL :
                    powerDownType ? synth_pkg::PM_UNDEF : synth_pkg::PM_NORMAL;
        case (powerMode)
            synth_pkg::PM_NORMAL: begin
                next_rfEnable = 1'b1;
                next_synthEnable = 1'b1;
            end
            synth_pkg::PM_PARTIAL: begin
                next_rfEnable = 1'b0; // see R5
                next_synthEnable = 1'b1;
            end
            synth_pkg::PM_OFF: begin
                next_rfEnable = 1'b0;
                next_synthEnable = 1'b0;
            end
            default: begin
                next_rfEnable = 1'b1;
                next_synthEnable = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rfEnable <= 1'b1;
            synthEnable <= 1'b1;
        end else begin
            rfEnable <= next_rfEnable;
            synthEnable <= next_synthEnable;
        end
    end

    // ==========================================================
    // main path and second LO, fed from the vco prescaler

    logic pre2;
    logic [7:0] cnt3;
    logic [7:0] mainCnt;
    logic [7:0] lo2Cnt;
    logic mainFix;
    logic mainHalf;
    logic prePulse;
    logic p3;
    logic nPulse;
    logic lPulse;
    assign prePulse = vcoRise && pre2 && synthEnable;
    assign p3 = prePulse && wrapCount(cnt3, 8'h03) == 8'h00;
    assign nPulse = p3 && wrapCount(mainCnt, {1'b0, mainValue}) == 8'h00;
    assign lPulse = prePulse && rfEnable && wrapCount(lo2Cnt, {4'h0, lo2Value}) == 8'h00;

    // chained pulses, each stage only moves on its feeder's pulse
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre2 <= 1'b0;
            cnt3 <= 8'h00;
            mainCnt <= 8'h00;
            mainFix <= 1'b0;
            mainHalf <= 1'b0;
        end else begin
            if (vcoRise && synthEnable) begin
                pre2 <= ~pre2; // see R12
            end
            if (prePulse) begin
                cnt3 <= wrapCount(cnt3, 8'h03);
            end
            if (p3) begin
                mainCnt <= wrapCount(mainCnt, {1'b0, mainValue});
            end
            if (nPulse) begin
                mainFix <= ~mainFix; // see R11
            end
            if (nPulse && mainFix) begin
                mainHalf <= ~mainHalf; // see R9
            end
        end
    end

    // second LO stops in both power-down modes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lo2Cnt <= 8'h00;
            lo2Out <= 1'b0;
        end else begin
            if (prePulse && rfEnable) begin
                lo2Cnt <= wrapCount(lo2Cnt, {4'h0, lo2Value}); // see R13
            end
            if (lPulse) begin
                lo2Out <= ~lo2Out;
            end
        end
    end

    // ==========================================================
    // reference path

    logic [7:0] refCnt;
    logic refLevel;
    logic refHalf;
    logic refPulse;
    assign refPulse = refRise && synthEnable && wrapCount(refCnt, {3'h0, refValue}) == 8'h00;

    // undivided output is high for half the ratio, rounded down, so only odd ratios give an uneven mark/space
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            refCnt <= 8'h00;
            refLevel <= 1'b0;
            refHalf <= 1'b0;
        end else begin
            if (refRise && synthEnable) begin
                refCnt <= wrapCount(refCnt, {3'h0, refValue}); // see R14
            end
            refLevel <= refCnt < {4'h0, refValue[4:1]};
            if (refPulse) begin
                refHalf <= ~refHalf; // see R8
            end
        end
    end

    // ==========================================================
    // phase detector ports, registered

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            refPdOut <= 1'b0;
            mainPdOut <= 1'b0;
        end else begin
            refPdOut <= refSel ? refLevel : refHalf; // see R6
            mainPdOut <= mainSel ? mainFix : mainHalf; // see R9
        end
    end

    // ==========================================================
    // checks

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence fullWordStrobe;
        latchRise && bitCount == `SYN_WORD_BITS;
    endsequence

    sequence bothPowerDown;
        (powerDownEnable && powerDownType) [*2];
    endsequence

    a_shift_takes_bit: assert property (sclkRise && latchLow |=> shiftWord[0] == $past(dataS)) // see R1
        else $error("serial bit not shifted in");
    a_word_loads: assert property (fullWordStrobe |=> activeWord == $past(shiftWord)) // see R16
        else $error("full word not loaded on latch rise");
    a_hold_while_low: assert property (latchLow |=> $stable(activeWord)) // see R17
        else $error("settings moved while latch low");
    a_default_after_reset: assert property ($past(sys_rst) |-> activeWord == `SYN_DEFAULT_WORD) // see R3
        else $error("default word missing after reset");
    a_complete_power_down: assert property (bothPowerDown |-> !synthEnable && !rfEnable) // see R5
        else $error("complete power-down not applied");
    a_div3_wrap: assert property (p3 |-> cnt3 == `SYN_DIV3_LAST) // see R12
        else $error("divide-by-3 wrapped at wrong count");
    a_main_fixed_half: assert property (nPulse |=> mainFix != $past(mainFix)) // see R11
        else $error("main fixed halver missed a pulse");
    a_main_wrap: assert property (p3 && mainCnt == 8'({1'b0, mainValue} - 8'h01)
        |=> mainCnt == 8'h00) // see R10
        else $error("main divider did not wrap");
    a_ref_wrap: assert property (refRise && synthEnable
        && refCnt == 8'({3'h0, refValue} - 8'h01) |=> refCnt == 8'h00) // see R7
        else $error("reference divider did not wrap");
    a_ref_half_hold: assert property (!refPulse |=> $stable(refHalf)) // see R8
        else $error("reference halver moved without a pulse");
    a_ref_post_mux: assert property (refSel && $stable(refSel) |=> refPdOut == $past(refLevel)) // see R6
        else $error("undivided reference not passed");
    a_main_post_mux: assert property (!mainSel ##1 !mainSel |-> mainPdOut == $past(mainHalf)) // see R9
        else $error("main halver not selected");
    a_lo2_toggle: assert property (lPulse |=> lo2Out != $past(lo2Out)) // see R13
        else $error("second LO output missed a toggle");
    a_lo2_wrap: assert property (lPulse |=> lo2Cnt == 8'h00) // see R15
        else $error("second LO divider did not wrap");

endmodule

// file: tb/synth_host.sv
// host controller model driving the three-wire program port
`timescale 1ns/1ns
module synth_host (
    input wire logic clk,
    output logic serialData,
    output logic serialClock,
    output logic loadLatch
);
    // ==========================================================
    // link timing: 160 ns serial clock, 80 ns each level
    localparam int HALF_CYC = 8;
    // idle: clock parked high so the latch may move at once
    initial begin
        serialData = 1'b0;
        serialClock = 1'b1;
        loadLatch = 1'b1;
    end
    // whole system cycles, then step just past the edge
    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // shift nbits msb first then latch; fewer than 20 is a refused load
    task automatic sendWord(input logic [19:0] w, input int nbits);
        waitc(HALF_CYC);
        loadLatch = 1'b0; // clock high 80 ns before
        for (int i = 0; i < nbits; i++) begin
            waitc(HALF_CYC);
            serialClock = 1'b0;
            serialData = w[19 - i]; // enable bit first, lo2 last
            waitc(HALF_CYC);
            serialClock = 1'b1; // data stood 80 ns
        end
        waitc(HALF_CYC);
        loadLatch = 1'b1; // after the last of the nbits and clock high
        waitc(HALF_CYC);
        serialData = ~serialData; // released line must not keep last bit
    endtask
endmodule

// file: tb/serial_programmed_synth_dividers_bench.sv
// self-checking bench for the synthesizer program port and dividers
`timescale 1ns/1ns
module serial_programmed_synth_dividers_bench;
    // ==========================================================
    // clocks, pins and bookkeeping
    typedef struct {
        int kind;
        logic [31:0] value;
    } note_t;
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    logic vcoClock = 1'b0;
    logic refClock = 1'b0;
    wire logic serialData;
    wire logic serialClock;
    wire logic loadLatch;
    logic powerDownEnable, powerDownType, rfEnable, synthEnable;
    logic refPdOut, mainPdOut, lo2Out;
    note_t notes[$];
    note_t cur;
    logic [31:0] seen;
    logic [19:0] word;
    logic [19:0] last;
    int numErrors = 0;
    int compares = 0;
    integer seed = 32'h56aa;

    serial_programmed_synth_dividers dut (
        .clk(clk), .sys_rst(sysRst), .serialData(serialData),
        .serialClock(serialClock), .loadLatch(loadLatch), .vcoClock(vcoClock),
        .refClock(refClock), .powerDownEnable(powerDownEnable),
        .powerDownType(powerDownType), .rfEnable(rfEnable), .synthEnable(synthEnable),
        .refPdOut(refPdOut), .mainPdOut(mainPdOut), .lo2Out(lo2Out)
    );
    synth_host host (
        .clk(clk), .serialData(serialData), .serialClock(serialClock),
        .loadLatch(loadLatch)
    );

    // ==========================================================
    // clocks: vco 40 ns, reference 60 ns, both stepped off the edge
    always #5 clk = ~clk;
    always begin
        repeat (2) @(posedge clk);
        #1 vcoClock = ~vcoClock;
    end
    always begin
        repeat (3) @(posedge clk);
        #1 refClock = ~refClock;
    end

    // ==========================================================
    // reporting
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            numErrors++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask
    task automatic finalReport();
        $display("compares %0d mismatches %0d", compares, numErrors);
        if (numErrors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================================
    // measuring: status bits, or one settled period in clk cycles
    function automatic logic pick(input int kind);
        case (kind)
            1: return refPdOut;
            2: return mainPdOut;
            default: return lo2Out;
        endcase
    endfunction
    task automatic measure(input int kind, output logic [31:0] got);
        int cnt;
        int rises;
        int guard;
        logic p;
        logic s;
        got = 'x;
        cnt = 0;
        rises = 0;
        guard = 0;
        p = pick(kind);
        if (kind == 0) begin
            repeat (2) @(negedge clk);
            got = {28'h0, powerDownEnable, powerDownType, rfEnable, synthEnable};
        end
        // first period skipped: a fresh ratio may leave one odd cycle
        while (kind != 0 && rises < 3 && guard < 40000) begin
            @(negedge clk);
            s = pick(kind);
            cnt++;
            guard++;
            if (s === 1'b1 && p === 1'b0) begin
                rises++;
                if (rises == 3) got = cnt;
                cnt = 0;
            end
            p = s;
        end
    endtask

    // notes the expected status and periods, then waits for the monitor
    task automatic expectPlan(input logic [19:0] w, input bit full);
        note_t n;
        n.kind = 0;
        n.value = {28'h0, w[19], w[18], ~w[19], ~(w[19] & w[18])};
        notes.push_back(n);
        if (full) begin
            n.kind = 1;
            n.value = (w[17] ? 6 : 12) * w[16:12];
            notes.push_back(n);
            n.kind = 2;
            n.value = (w[11] ? 48 : 96) * w[10:4];
            notes.push_back(n);
            n.kind = 3;
            n.value = 16 * w[3:0];
            notes.push_back(n);
        end
        wait (notes.size() == 0);
    endtask

    // monitor: oldest note against what the outputs show
    initial begin
        forever begin
            wait (notes.size() > 0);
            cur = notes[0];
            measure(cur.kind, seen);
            case (cur.kind)
                0: check(seen, cur.value);
                1: check(seen, cur.value);
                2: check(seen, cur.value);
                default: check(seen, cur.value);
            endcase
            void'(notes.pop_front());
        end
    end

    // watchdog well past the longest expected run, about 80k clk cycles
    initial begin
        #800000;
        numErrors++;
        finalReport();
    end

    // ==========================================================
    // test sequence
    initial begin
        repeat (2) @(posedge clk);
        #1;
        sysRst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        last = {3'h0, 5'h04, 1'h1, 7'h47, 4'ha};
        expectPlan(last, 1'b1);
        $display("test 1 done: default plan");
        // select bits opposite to the default, so both post-scaler paths are seen
        word = {2'h0, 1'h1, 5'(4 + {$random(seed)} % 28),
            1'h0, 7'(64 + {$random(seed)} % 64),
            4'(4 + {$random(seed)} % 12)};
        host.sendWord(word, 20);
        expectPlan(word, 1'b1);
        last = word;
        $display("test 2 done: random word");
        host.sendWord(~word, 19);
        expectPlan(last, 1'b0);
        $display("test 3 done: short word refused");
        // partial, undefined and complete power-down codes
        for (int m = 1; m < 4; m++) begin
            word = {2'(m), last[17:0]};
            host.sendWord(word, 20);
            expectPlan(word, 1'b0);
        end
        $display("test 4 done: power-down codes");
        finalReport();
    end
endmodule
